// [dcs_pkg.sv]
package dcs_pkg;
  // clock of this controller, in picoseconds per cycle
  localparam int CLK_PS = 5000;
  // timing figures as printed, in picoseconds
  localparam int CCD_L_PS = 5000;
  localparam int RRD_S_2K_PS = 5300;
  localparam int RRD_L_2K_PS = 6400;
  localparam int RRD_L_1K_PS = 4900;
  localparam int FAW_2K_PS = 30000;
  localparam int FAW_1K_PS = 21000;
  localparam int WTR_S_PS = 2500;
  localparam int WTR_L_PS = 7500;
  localparam int RTP_PS = 7500;
  localparam int WR_PS = 15000;
  localparam int CRC_DM_PS = 3750;
  localparam int MOD_PS = 15000;
  localparam int CAL_PS = 3748;
  localparam int DLL_OFF_MIN_PS = 8000;
  localparam int DLL_OFF_MAX_PS = 20000;
  // cycle minimums as printed
  localparam int CCD_L_NCK = 5;
  localparam int CCD_S_NCK = 4;
  localparam int RRD_NCK = 4;
  localparam int FAW_2K_NCK = 28;
  localparam int FAW_1K_NCK = 20;
  localparam int WTR_S_NCK = 2;
  localparam int WTR_L_NCK = 4;
  localparam int RTP_NCK = 4;
  localparam int CRC_DM_NCK = 5;
  localparam int MRD_NCK = 8;
  localparam int MOD_NCK = 24;
  localparam int MPRR_NCK = 1;
  localparam int CAL_NCK = 3;
  localparam int WTR_START_BC4 = 2;
  localparam int WTR_START_BL8 = 4;

  // round up, floor
  // least time in ps to whole cycles, rounded up, then max with cycle floor
  function automatic int cyc(input int ps, input int nck);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    if (c < 1) c = 1;
    return (c > nck) ? c : nck;
  endfunction

  localparam int T_CCD_L = cyc(CCD_L_PS, CCD_L_NCK);
  localparam int T_CCD_S = CCD_S_NCK;
  localparam int T_RRD_S = cyc(RRD_S_2K_PS, RRD_NCK);
  localparam int T_RRD_L2 = cyc(RRD_L_2K_PS, RRD_NCK);
  localparam int T_RRD_L1 = cyc(RRD_L_1K_PS, RRD_NCK);
  localparam int T_FAW2 = cyc(FAW_2K_PS, FAW_2K_NCK);
  localparam int T_FAW1 = cyc(FAW_1K_PS, FAW_1K_NCK);
  localparam int T_WTR_S = cyc(WTR_S_PS, WTR_S_NCK);
  localparam int T_WTR_L = cyc(WTR_L_PS, WTR_L_NCK);
  localparam int T_RTP = cyc(RTP_PS, RTP_NCK);
  localparam int T_WR = cyc(WR_PS, 1);
  localparam int T_CRC = cyc(CRC_DM_PS, CRC_DM_NCK);
  localparam int T_MRD = MRD_NCK;
  localparam int T_MOD = cyc(MOD_PS, MOD_NCK);
  localparam int T_CAL = cyc(CAL_PS, CAL_NCK);
  localparam int T_MPRR = MPRR_NCK;

  // command codes on the user port
  typedef enum logic [2:0] {
    DCS_NOP = 3'h0, DCS_ACT = 3'h1, DCS_RD = 3'h2, DCS_WR = 3'h3,
    DCS_PRE = 3'h4, DCS_MRS = 3'h5, DCS_MPR_RD = 3'h6, DCS_MPR_WR = 3'h7
  } dcs_cmd_t;

  // issue sequencer states, gray from idle through wait to select
  typedef enum logic [1:0] {
    DCS_IDLE = 2'b00, DCS_WAIT = 2'b01, DCS_SEL = 2'b11
  } dcs_state_t;
endpackage

// [dcs_down_timer.sv]
`timescale 1ns/1ps
`default_nettype none
// loadable down counter; ready when zero, load keeps the larger value
module dcs_down_timer #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // load
  input wire logic load,
  input wire logic [W-1:0] value,
  // state
  output logic ready
);
  logic [W-1:0] cnt_reg;
  // a smaller reload never shortens a pending wait
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (load && value > cnt_reg) begin
      cnt_reg <= value;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end
  assign ready = (cnt_reg == '0);
endmodule // dcs_down_timer
`default_nettype wire

// [dcs_act_window.sv]
`timescale 1ns/1ps
`default_nettype none
// four-activate window: remembers age of the last four activates
module dcs_act_window #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // activate seen and window length
  input wire logic act,
  input wire logic [W-1:0] window,
  // state
  output logic ready
);
  logic [W-1:0] age_reg [4];
  // shift register of remaining windows, oldest in slot 3
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < 4; i++) age_reg[i] <= '0;
    end else if (act) begin
      // slot 0 takes the new window, older slots age while shifting
      age_reg[0] <= window - 1'b1;
      for (int i = 1; i < 4; i++) begin
        age_reg[i] <= (age_reg[i-1] != '0) ? age_reg[i-1] - 1'b1 : '0;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (age_reg[i] != '0) age_reg[i] <= age_reg[i] - 1'b1;
      end
    end
  end
  // a fifth activate waits until the oldest of four has aged out
  assign ready = (age_reg[3] == '0);
endmodule // dcs_act_window
`default_nettype wire

// [dcs_spacing_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module dcs_spacing_ctrl
  import dcs_pkg::*;
#(
  parameter int BANKS_PER_GROUP = 4,
  parameter int GROUPS = 2,
  parameter int TW = 8,
  parameter int WL_DEF = 16,
  parameter int RP_CYC = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // mode settings
  input wire logic page_2k,
  input wire logic crc_dm_en,
  input wire logic fixed_bc4,
  input wire logic cal_mode,
  input wire logic dll_off,
  input wire logic [5:0] write_latency,
  input wire logic [5:0] additive_latency,
  input wire logic [3:0] parity_latency,
  input wire logic [5:0] wr_programmed,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [2:0] req_cmd,
  input wire logic req_auto_pre,
  input wire logic [$clog2(GROUPS)-1:0] req_group,
  input wire logic [$clog2(BANKS_PER_GROUP)-1:0] req_bank,
  // device command pins
  output logic cs_n_reg,
  output logic [2:0] cmd_reg,
  output logic [$clog2(GROUPS)-1:0] group_reg,
  output logic [$clog2(BANKS_PER_GROUP)-1:0] bank_reg,
  output logic auto_pre_reg,
  // status
  output logic dll_clock_ok
);
  localparam int NB = GROUPS * BANKS_PER_GROUP;
  localparam int CW = TW;

  dcs_state_t state_reg, state_next;
  dcs_cmd_t cmd_in;
  logic issue;
  logic [$clog2(CAL_NCK + T_CAL + 1)-1:0] cal_cnt_reg;
  logic [CW-1:0] wr_start_cyc;

  assign cmd_in = dcs_cmd_t'(req_cmd);

  // timers; per group ready signals
  logic [GROUPS-1:0] col_l_rdy, act_l_rdy, wtr_l_rdy;
  logic [NB-1:0] pre_rdy;
  logic col_s_rdy, act_s_rdy, wtr_s_rdy, mrd_rdy, mod_rdy, mpr_rdy, faw_rdy;
  logic col_any, act_any, wr_any, rd_any, pre_any, mrs_any;

  // decoded strobes at the moment a command leaves
  assign col_any = issue && (cmd_in == DCS_RD || cmd_in == DCS_WR);
  assign act_any = issue && cmd_in == DCS_ACT;
  assign wr_any = issue && cmd_in == DCS_WR;
  assign rd_any = issue && cmd_in == DCS_RD;
  assign pre_any = issue && cmd_in == DCS_PRE;
  assign mrs_any = issue && cmd_in == DCS_MRS;

  assign wr_start_cyc = CW'(write_latency) + (fixed_bc4 ? CW'(WTR_START_BC4) : CW'(WTR_START_BL8));

  // crc and mask extension shared by write-to-read turnaround and write recovery without auto precharge
  function automatic logic [CW-1:0] ext(input logic en);
    return en ? CW'(T_CRC) : '0;
  endfunction

  function automatic logic [CW-1:0] cal_ext(input logic en);
    return en ? CW'(T_CAL) : '0;
  endfunction

  genvar g;
  generate
    for (g = 0; g < GROUPS; g++) begin : g_grp
      logic hit;
      assign hit = (req_group == ($clog2(GROUPS))'(g));
      dcs_down_timer #(.W(CW)) u_col (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .load(col_any && hit),
        .value(CW'(T_CCD_L - 1)), .ready(col_l_rdy[g]));
      dcs_down_timer #(.W(CW)) u_act (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .load(act_any && hit),
        .value(page_2k ? CW'(T_RRD_L2 - 1) : CW'(T_RRD_L1 - 1)), .ready(act_l_rdy[g]));
      dcs_down_timer #(.W(CW)) u_wtr (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .load(wr_any && hit),
        .value(wr_start_cyc + CW'(T_WTR_L) + ext(crc_dm_en) - 1'b1), .ready(wtr_l_rdy[g]));
    end
  endgenerate

  genvar b;
  generate
    for (b = 0; b < NB; b++) begin : g_bank
      logic hit;
      logic [CW-1:0] val;
      assign hit = ({req_group, req_bank} == ($clog2(NB))'(b));
      // read to precharge; write recovery, plus precharge if auto
      always_comb begin
        if (cmd_in == DCS_RD) val = CW'(T_RTP - 1);
        else if (req_auto_pre) val = wr_start_cyc + CW'(wr_programmed) + CW'(RP_CYC) - 1'b1;
        else val = wr_start_cyc + CW'(T_WR) + ext(crc_dm_en) - 1'b1;
      end
      dcs_down_timer #(.W(CW)) u_pre (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .load((rd_any || wr_any) && hit),
        .value(val), .ready(pre_rdy[b]));
    end
  endgenerate

  dcs_down_timer #(.W(CW)) u_col_s (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .load(col_any),
    .value(CW'(T_CCD_S - 1)), .ready(col_s_rdy));
  dcs_down_timer #(.W(CW)) u_act_s (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .load(act_any),
    .value(CW'(T_RRD_S - 1)), .ready(act_s_rdy));
  dcs_down_timer #(.W(CW)) u_wtr_s (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .load(wr_any),
    .value(wr_start_cyc + CW'(T_WTR_S) + ext(crc_dm_en) - 1'b1), .ready(wtr_s_rdy));
  dcs_down_timer #(.W(CW)) u_mrd (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .load(mrs_any),
    .value(CW'(T_MRD - 1) + cal_ext(cal_mode)), .ready(mrd_rdy));
  // update delay; multipurpose write adds latencies
  dcs_down_timer #(.W(CW)) u_mod (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .load(mrs_any || (issue && cmd_in == DCS_MPR_WR)),
    .value(CW'(T_MOD - 1) + cal_ext(cal_mode) +
      ((cmd_in == DCS_MPR_WR) ? CW'(additive_latency) + CW'(parity_latency) : '0)),
    .ready(mod_rdy));
  dcs_down_timer #(.W(CW)) u_mpr (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .load(issue && cmd_in == DCS_MPR_RD),
    .value(CW'(T_MPRR)), .ready(mpr_rdy));
  dcs_act_window #(.W(CW)) u_faw (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .act(act_any),
    .window(page_2k ? CW'(T_FAW2) : CW'(T_FAW1)), .ready(faw_rdy));

  // legality of the pending request
  logic legal;
  always_comb begin
    legal = mpr_rdy && (mod_rdy || cmd_in == DCS_MRS);
    unique case (cmd_in)
      DCS_ACT: legal = legal && act_s_rdy && act_l_rdy[req_group] && faw_rdy;
      DCS_RD: legal = legal && col_s_rdy && col_l_rdy[req_group] && wtr_s_rdy
        && wtr_l_rdy[req_group];
      DCS_WR: legal = legal && col_s_rdy && col_l_rdy[req_group];
      DCS_PRE: legal = legal && pre_rdy[{req_group, req_bank}];
      DCS_MRS: legal = legal && mrd_rdy;
      DCS_NOP, DCS_MPR_RD, DCS_MPR_WR: legal = legal;
    endcase
  end

  // select latency: cs_n drops, command follows after the latency
  always_comb begin
    state_next = state_reg;
    issue = 1'b0;
    unique case (state_reg)
      DCS_IDLE: if (req_valid && legal) begin
        if (cal_mode) state_next = DCS_WAIT;
        else issue = 1'b1;
      end
      DCS_WAIT: if (cal_cnt_reg == '0) state_next = DCS_SEL;
      DCS_SEL: begin
        issue = 1'b1;
        state_next = DCS_IDLE;
      end
      default: state_next = DCS_IDLE;
    endcase
  end
  assign req_ready = issue;

  // sequencer state
  always_ff @(posedge clk_sys) begin
    if (sys_rst) state_reg <= DCS_IDLE;
    else state_reg <= state_next;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) cal_cnt_reg <= '0;
    else if (state_reg == DCS_IDLE && state_next == DCS_WAIT)
      cal_cnt_reg <= ($bits(cal_cnt_reg))'(T_CAL - 2);
    else if (cal_cnt_reg != '0) cal_cnt_reg <= cal_cnt_reg - 1'b1;
  end

  // pin register; cs_n also low while the next state is DCS_WAIT
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cs_n_reg <= 1'b1;
      cmd_reg <= DCS_NOP;
      group_reg <= '0;
      bank_reg <= '0;
      auto_pre_reg <= 1'b0;
    end else begin
      cs_n_reg <= !(issue || state_next == DCS_WAIT);
      cmd_reg <= issue ? req_cmd : DCS_NOP;
      group_reg <= req_group;
      bank_reg <= req_bank;
      auto_pre_reg <= issue && req_auto_pre;
    end
  end

  // clock range check with loop off; 5 ns clock lies outside it
  assign dll_clock_ok = !dll_off || (CLK_PS >= DLL_OFF_MIN_PS && CLK_PS <= DLL_OFF_MAX_PS);

  // a_col_same_grp
  a_col_same_grp: assert property (@(posedge clk_sys) disable iff (sys_rst)
    col_any ##1 1 |-> !(col_any && req_group == $past(req_group)))
    else $error("column commands in one group too close");
  // a_act_other
  a_act_other: assert property (@(posedge clk_sys) disable iff (sys_rst)
    act_any |=> !act_any [*3]) else $error("activates too close");
  // a_mrs_space
  a_mrs_space: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mrs_any |=> !mrs_any [*7]) else $error("mode sets too close");
  // a_mod_wait
  a_mod_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
    mrs_any && !cal_mode |=> !(issue && cmd_in != DCS_MRS) [*8])
    else $error("command inside update delay");
  // a_col_any
  a_col_any: assert property (@(posedge clk_sys) disable iff (sys_rst)
    col_any |=> !col_any [*3]) else $error("column commands too close");
  // a_mpr_rec
  a_mpr_rec: assert property (@(posedge clk_sys) disable iff (sys_rst)
    issue && cmd_in == DCS_MPR_RD |=> !issue) else $error("no recovery after mpr read");
  // a_cal_lat
  a_cal_lat: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_reg == DCS_IDLE && state_next == DCS_WAIT |-> ##[1:4] issue)
    else $error("select latency not kept");
  // a_rd_pre
  a_rd_pre: assert property (@(posedge clk_sys) disable iff (sys_rst)
    rd_any ##1 pre_any |-> 0) else $error("precharge right after read");
  c_act: cover property (@(posedge clk_sys) act_any);
  c_wr_rd: cover property (@(posedge clk_sys) wr_any ##[1:40] rd_any);
  c_cal: cover property (@(posedge clk_sys) state_reg == DCS_SEL);
endmodule // dcs_spacing_ctrl
`default_nettype wire

// [dcs_dram_model.sv]
`timescale 1ns/1ps
`default_nettype none
// device-side view of the command pins: tallies commands and spacing breaches
module dcs_dram_model
  import dcs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // command pins
  input wire logic cs_n_reg,
  input wire logic [2:0] cmd_reg,
  input wire logic group_reg,
  // mode
  input wire logic page_2k,
  // tallies
  output int n_cmds,
  output int n_bad
);
  int now;
  int mrs_t;
  int col_t[2];
  int act_t[2];
  int faw_q[$];

  // behavioural watch; a real part would just misbehave, here it is counted
  always @(posedge clk_sys) begin
    now = now + 1;
    if (sys_rst) begin
      n_cmds = 0;
      n_bad = 0;
      mrs_t = -100;
      col_t = '{-100, -100};
      act_t = '{-100, -100};
      faw_q = {};
    end else if (!cs_n_reg && cmd_reg != DCS_NOP) begin
      // a bare select with no command only opens the select latency
      n_cmds++;
      if (cmd_reg != DCS_MRS && now - mrs_t < MOD_NCK) n_bad++;
      case (cmd_reg)
        DCS_RD, DCS_WR: begin
          if (now - col_t[group_reg] < CCD_L_NCK) n_bad++;
          if (now - col_t[group_reg ^ 1'b1] < CCD_S_NCK) n_bad++;
          col_t[group_reg] = now;
        end
        DCS_ACT: begin
          if (now - act_t[group_reg] < RRD_NCK) n_bad++;
          if (now - act_t[group_reg ^ 1'b1] < RRD_NCK) n_bad++;
          if (faw_q.size() == 4 && now - faw_q[0] < (page_2k ? FAW_2K_NCK : FAW_1K_NCK)) n_bad++;
          if (faw_q.size() == 4) void'(faw_q.pop_front());
          faw_q.push_back(now);
          act_t[group_reg] = now;
        end
        DCS_MRS: begin
          if (now - mrs_t < MRD_NCK) n_bad++;
          mrs_t = now;
        end
        default: begin
        end
      endcase
    end
  end
endmodule // dcs_dram_model
`default_nettype wire

// [test_ddr4_command_spacing_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module test_ddr4_command_spacing_checker
  import dcs_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic page_2k = 1'b1, crc_dm_en = 1'b0, fixed_bc4 = 1'b0, dll_off = 1'b0;
  logic [5:0] write_latency = 6'h04, additive_latency = 6'h00, wr_programmed = 6'h05;
  logic [3:0] parity_latency = 4'h1;
  logic req_valid = 1'b0, req_group = 1'b0, cal_mode = 1'b0, req_auto_pre = 1'b0;
  logic [2:0] req_cmd = 3'h0;
  logic [1:0] req_bank = 2'h0;
  logic req_ready, cs_n_reg, auto_pre_reg, dll_clock_ok, group_reg;
  logic [2:0] cmd_reg;
  logic [1:0] bank_reg;
  int num_errors = 0, comparisons = 0, now = 0, issued = 0, n_cmds, n_bad;

  // 200 MHz clock and an edge counter for spacing
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) now <= now + 1;

  dcs_spacing_ctrl dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .page_2k(page_2k),
    .crc_dm_en(crc_dm_en), .fixed_bc4(fixed_bc4), .cal_mode(cal_mode), .dll_off(dll_off),
    .write_latency(write_latency), .additive_latency(additive_latency),
    .parity_latency(parity_latency), .wr_programmed(wr_programmed), .req_valid(req_valid),
    .req_ready(req_ready), .req_cmd(req_cmd), .req_auto_pre(req_auto_pre), .req_group(req_group),
    .req_bank(req_bank), .cs_n_reg(cs_n_reg), .cmd_reg(cmd_reg), .group_reg(group_reg),
    .bank_reg(bank_reg), .auto_pre_reg(auto_pre_reg), .dll_clock_ok(dll_clock_ok));

  dcs_dram_model model (.clk_sys(clk_sys), .sys_rst(sys_rst), .cs_n_reg(cs_n_reg),
    .cmd_reg(cmd_reg), .group_reg(group_reg), .page_2k(page_2k), .n_cmds(n_cmds),
    .n_bad(n_bad));

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // time rounded up to whole cycles, floored at the cycle minimum
  function automatic int need(input int ps, input int nck);
    int c;
    c = (ps + 4999) / 5000;
    return (c > nck) ? c : nck;
  endfunction

  // request held until taken; valid stays up so back-to-back needs no gap
  task automatic issue(input logic [2:0] cmd, input logic grp, input logic [1:0] bank,
                       output int t);
    int n;
    n = 0;
    req_cmd = cmd;
    req_group = grp;
    req_bank = bank;
    req_valid = 1'b1;
    @(negedge clk_sys);
    while (!req_ready && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    check(n < 400, 1'b1);
    @(posedge clk_sys);
    #1;
    t = now;
    issued++;
  endtask

  task automatic idle(input int k);
    req_valid = 1'b0;
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  // two commands, first to group 0 bank 0; gap between takes is judged
  task automatic pair(input logic [2:0] c1, input logic [2:0] c2, input logic g2,
                      input logic [1:0] b2, input int want);
    int a, b;
    issue(c1, 1'b0, 2'h0, a);
    issue(c2, g2, b2, b);
    idle(40);
    check(b - a, want);
  endtask

  task automatic sc_column();
    int a, b, c;
    issue(DCS_RD, 1'b0, 2'h0, a);
    issue(DCS_RD, 1'b0, 2'h1, b);
    issue(DCS_RD, 1'b1, 2'h0, c);
    check({cs_n_reg, cmd_reg, group_reg, bank_reg, auto_pre_reg}, {1'b0, DCS_RD, 1'b1, 2'h0, 1'b0});
    idle(40);
    check(b - a, need(CCD_L_PS, CCD_L_NCK));
    check(c - b, CCD_S_NCK);
  endtask

  task automatic sc_act(input logic p2k, input int faw);
    int a, b, c, d, e;
    page_2k = p2k;
    issue(DCS_ACT, 1'b0, 2'h0, a);
    issue(DCS_ACT, 1'b1, 2'h0, b);
    issue(DCS_ACT, 1'b1, 2'h1, c);
    issue(DCS_ACT, 1'b0, 2'h1, d);
    issue(DCS_ACT, 1'b1, 2'h2, e);
    idle(40);
    check(b - a, need(RRD_S_2K_PS, RRD_NCK));
    check(c - b, need(p2k ? RRD_L_2K_PS : RRD_L_1K_PS, RRD_NCK));
    check(e - a, faw);
  endtask

  task automatic sc_turnaround();
    int ws, wl, crc;
    ws = need(WTR_S_PS, WTR_S_NCK);
    wl = need(WTR_L_PS, WTR_L_NCK);
    crc = need(CRC_DM_PS, CRC_DM_NCK);
    pair(DCS_WR, DCS_RD, 1'b1, 2'h1, 4 + WTR_START_BL8 + ws);
    pair(DCS_WR, DCS_RD, 1'b0, 2'h1, 4 + WTR_START_BL8 + wl);
    pair(DCS_RD, DCS_PRE, 1'b0, 2'h0, need(RTP_PS, RTP_NCK));
    pair(DCS_WR, DCS_PRE, 1'b0, 2'h0, 4 + WTR_START_BL8 + need(WR_PS, 1));
    fixed_bc4 = 1'b1;
    pair(DCS_WR, DCS_RD, 1'b1, 2'h1, 4 + WTR_START_BC4 + ws);
    fixed_bc4 = 1'b0;
    // precharge time taken as three cycles at this clock
    req_auto_pre = 1'b1;
    pair(DCS_WR, DCS_PRE, 1'b0, 2'h0, write_latency + WTR_START_BL8 + wr_programmed + 3);
    req_auto_pre = 1'b0;
    crc_dm_en = 1'b1;
    pair(DCS_WR, DCS_RD, 1'b0, 2'h1, 4 + WTR_START_BL8 + wl + crc);
    pair(DCS_WR, DCS_PRE, 1'b0, 2'h0, 4 + WTR_START_BL8 + need(WR_PS, 1) + crc);
    crc_dm_en = 1'b0;
  endtask

  task automatic sc_mode();
    int a, b, c;
    issue(DCS_MRS, 1'b0, 2'h0, a);
    issue(DCS_MRS, 1'b0, 2'h0, b);
    issue(DCS_RD, 1'b1, 2'h0, c);
    idle(40);
    check(b - a, MRD_NCK);
    check(c - b, need(MOD_PS, MOD_NCK));
    additive_latency = 6'h02;
    pair(DCS_MPR_WR, DCS_RD, 1'b1, 2'h0, need(MOD_PS, MOD_NCK) + 2 + 1);
    additive_latency = 6'h00;
    pair(DCS_MPR_RD, DCS_RD, 1'b1, 2'h0, MPRR_NCK + 1);
  endtask

  // select falls first, the command follows after the latency
  task automatic sc_cal();
    int e0, a;
    cal_mode = 1'b1;
    req_cmd = DCS_RD;
    req_group = 1'b0;
    req_bank = 2'h2;
    req_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    e0 = now;
    check({cs_n_reg, cmd_reg}, {1'b0, DCS_NOP});
    issue(DCS_RD, 1'b0, 2'h2, a);
    check({cs_n_reg, cmd_reg, bank_reg}, {1'b0, DCS_RD, 2'h2});
    idle(40);
    cal_mode = 1'b0;
    check(a - e0, need(CAL_PS, CAL_NCK));
  endtask

  task automatic sc_dll();
    dll_off = 1'b1;
    #1;
    check(dll_clock_ok, 1'b0);
    @(posedge clk_sys);
    #1;
    dll_off = 1'b0;
    #1;
    check(dll_clock_ok, 1'b1);
    @(posedge clk_sys);
    #1;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // watchdog: the full run needs under a thousand cycles
  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    @(posedge clk_sys);
    #1;
    sc_column();
    sc_act(1'b1, need(FAW_2K_PS, FAW_2K_NCK));
    sc_act(1'b0, need(FAW_1K_PS, FAW_1K_NCK));
    sc_turnaround();
    sc_mode();
    sc_dll();
    sc_cal();
    check(n_bad, 0);
    check(n_cmds, issued);
    end_of_test();
  end
endmodule // test_ddr4_command_spacing_checker
`default_nettype wire
